// File: bench/qdc_host_model.sv
/*
  Behavioural SPI host that plays the far side of the control register.
  Assumes the bench supplies the resolved serial-out line.
*/
`timescale 1ns/1ps
`default_nettype none
module qdc_host_model (
  output logic sclk,
  output logic cs_b,
  output logic sdi,
  input wire logic sdo_line
);
  // ==========================================================
  // idle levels: clock still, deselected
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    sdi = 1'b0;
  end
  // one frame, msb first, reply sampled on rising clock
  task automatic frame(input logic [23:0] tx, input int nbits,
    output logic [15:0] rx);
    logic [23:0] sh;
    sh = '0;
    cs_b = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      sdi = tx[23-i];
      #62.5 sclk = 1'b1;
      sh = {sh[22:0], sdo_line};
      #62.5 sclk = 1'b0;
    end
    #62.5 cs_b = 1'b1;
    sdi = ~sdi; // released line shows no stale level
    rx = sh[15:0];
    #200;
  endtask
endmodule
`default_nettype wire

// File: bench/testbench.sv
/*
  Self-checking bench for the quad converter control register.
  Assumes the host model drives the serial port at a 125 ns clock.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module testbench;
  import qdc_pkg::*;
  logic ref_clk, rst_b, pin_n, ext1, ext0;
  logic sclk, cs_b, sdi, sdo_out, sdo_oe;
  logic g1o, g1e, g0o, g0e;
  logic [3:0] pd, gain;
  logic [47:0] lat;
  logic [15:0] w, rx;
  int failures = 0;
  int check_count = 0;
  wire sdo_line = sdo_oe ? sdo_out : 1'bz;
  wire g1 = (g1e ? g1o : 1'b1) & ~ext1;
  wire g0 = (g0e ? g0o : 1'b1) & ~ext0;
  qdc_ctrl_top i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk),
    .cs_b(cs_b), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .load_latches_pin_n(pin_n), .gpio1_in(g1), .gpio1_out(g1o),
    .gpio1_oe(g1e), .gpio0_in(g0), .gpio0_out(g0o), .gpio0_oe(g0e),
    .channel_powerdown(pd), .channel_gain4(gain), .channel_latch(lat));
  qdc_host_model i_host (.sclk(sclk), .cs_b(cs_b), .sdi(sdi),
    .sdo_line(sdo_line));
  // ==========================================================
  // helpers
  function automatic logic [15:0] exp_rd(input logic [15:0] v);
    return (v & 16'h98bc) | {6'h0, v[9] & ~ext1, v[8] & ~ext0, 8'h0};
  endfunction
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    i_host.frame({4'h0, a, d}, 24, rx);
  endtask
  task automatic rd(input logic [3:0] a);
    i_host.frame({4'h8, a, 16'h0}, 24, rx);
    i_host.frame(24'h020000, 24, rx);
  endtask
  task automatic setp(input logic p, input logic e1, input logic e0);
    @(posedge ref_clk);
    #1 pin_n = p;
    ext1 = e1;
    ext0 = e0;
    repeat (10) @(posedge ref_clk);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // watchdog
  initial begin
    #500000;
    failures++;
    give_verdict();
  end
  // main sequence
  initial begin
    rst_b = 1'b0;
    pin_n = 1'b1;
    ext1 = 1'b0;
    ext0 = 1'b0;
    void'($urandom(32'h9dbca406));
    repeat (6) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    repeat (6) @(posedge ref_clk);
    `CHK({pd, gain, g1e, g0e, lat}, {8'h0f, 2'b00, 48'h0})
    rd(ADDR_CTRL);
    `CHK(rx, CTRL_RESET)
    for (int i = 0; i < 8; i++) begin
      w = 16'($urandom) & 16'h9f7f;
      if (i == 0) w = 16'h1c7f;
      setp(1'b1, 1'($urandom), 1'($urandom));
      wr(ADDR_CTRL, w);
      `CHK(pd, {w[11], w[11], w[12], w[12]})
      `CHK({g1e, g0e}, ~w[9:8])
      `CHK({g1o, g0o}, 2'b00)
      `CHK(gain, w[5:2])
      rd(ADDR_CTRL);
      `CHK(rx, exp_rd(w))
    end
    setp(1'b1, 1'b0, 1'b0);
    wr(ADDR_CTRL, 16'h1b3c);
    `CHK(pd, 4'hf)
    wr(ADDR_CTRL, CTRL_RESET);
    `CHK(pd, 4'h0)
    wr(ADDR_DATA0, 16'habc0);
    wr(4'h6, 16'h7770);
    `CHK(lat, 48'h0)
    wr(ADDR_CTRL, 16'h433c);
    `CHK(lat, 48'h000777000abc)
    rd(ADDR_CTRL);
    `CHK(rx, CTRL_RESET)
    wr(ADDR_DATA0, 16'h1230);
    wr(ADDR_CTRL, 16'h833c);
    rd(ADDR_DATA0);
    `CHK(rx, 16'habc0)
    wr(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_DATA0);
    `CHK(rx, 16'h1230)
    rd(4'h2);
    `CHK(rx, 16'h0000)
    setp(1'b0, 1'b0, 1'b0);
    `CHK(lat, 48'h000777000123)
    wr(4'h5, 16'h5550);
    wr(ADDR_CTRL, 16'h433c);
    `CHK(lat, 48'h000777000123)
    setp(1'b1, 1'b0, 1'b0);
    setp(1'b0, 1'b0, 1'b0);
    `CHK(lat, 48'h000777555123)
    setp(1'b1, 1'b0, 1'b0);
    i_host.frame(24'h001800, 23, rx);
    `CHK(pd, 4'h0)
    wr(ADDR_CTRL, 16'h03bc);
    rd(ADDR_CTRL);
    `CHK(rx, 16'hzzzz)
    wr(ADDR_CTRL, 16'h3800);
    `CHK({pd, gain, lat}, {8'h0f, 48'h0})
    rd(ADDR_CTRL);
    `CHK(rx, CTRL_RESET)
    // hardware reset in mid-run must give the same state
    wr(ADDR_CTRL, 16'h1820);
    wr(ADDR_DATA0, 16'h4560);
    setp(1'b0, 1'b0, 1'b0);
    `CHK({pd, gain, g1e, g0e, lat}, {8'hf8, 2'b11, 48'h456})
    @(posedge ref_clk);
    #1 rst_b = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    setp(1'b1, 1'b0, 1'b0);
    `CHK({pd, gain, g1e, g0e, lat}, {8'h0f, 2'b00, 48'h0})
    rd(ADDR_CTRL);
    `CHK(rx, CTRL_RESET)
    give_verdict();
  end
endmodule
`default_nettype wire

// File: logic/qdc_ctrl_top.sv
/*
  Control register bank of a quad converter behind an SPI slave port.
  Assumes the host SPI clock well below ref_clk/4 (125 ns bench period).
*/
`timescale 1ns/1ps
`default_nettype none
// How it works
// - sixteen-bit control register, resets to 033c
// - bit 15 picks input or latch readback
// - load bit copies inputs while pin high
// - only channels written since last load update
// - load bit clears itself after update
// - load bit ignored while load pin low
// - reset bit resets control, input and latch registers, self-clears
// - bit 12 powers down channels 0, 1
// - clearing bit 12 restores channels 0, 1
// - bit 11 powers down channels 2, 3
// - bit 10 reserved, reads zero
// - bit 9 clear drives pin 1 low, reads pin
// - bit 8 clear drives pin 0 low, reads pin
// - bit 7 set keeps serial out floating
// - bit 7 clear gives normal serial out
// - 24-bit frame, rw, address, data
// - read data appears in next frame
// - gain bits 5:2, bit 6 reads zero
module qdc_ctrl_top (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic sdi,
  output logic sdo_out,
  output logic sdo_oe,
  input wire logic load_latches_pin_n,
  input wire logic gpio1_in,
  output logic gpio1_out,
  output logic gpio1_oe,
  input wire logic gpio0_in,
  output logic gpio0_out,
  output logic gpio0_oe,
  output logic [qdc_pkg::NUM_CH-1:0] channel_powerdown,
  output logic [qdc_pkg::NUM_CH-1:0] channel_gain4,
  output logic [qdc_pkg::NUM_CH*12-1:0] channel_latch
);
  import qdc_pkg::*;
  // ==========================================================
  // synchronisers
  logic [1:0] sclk_sy, cs_sy, sdi_sy, ld_sy, g1_sy, g0_sy;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_sy <= 2'h0;
      cs_sy <= 2'h3;
      sdi_sy <= 2'h0;
      ld_sy <= 2'h3;
      g1_sy <= 2'h3;
      g0_sy <= 2'h3;
    end else begin
      sclk_sy <= {sclk_sy[0], sclk};
      cs_sy <= {cs_sy[0], cs_b};
      sdi_sy <= {sdi_sy[0], sdi};
      ld_sy <= {ld_sy[0], load_latches_pin_n};
      g1_sy <= {g1_sy[0], gpio1_in};
      g0_sy <= {g0_sy[0], gpio0_in};
    end
  end
  wire ld_pin = ld_sy[1];
  // ==========================================================
  // serial shifter
  qdc_frame_if fr ();
  logic sdo_bit;
  qdc_spi_shift u_shift (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sclk_s(sclk_sy[1]),
    .cs_b_s(cs_sy[1]),
    .sdi_s(sdi_sy[1]),
    .fr(fr.shifter),
    .sdo_bit(sdo_bit)
  );
  // ==========================================================
  // frame decode
  wire is_read = fr.frame[FRAME_RW_BIT];
  wire [3:0] addr = fr.frame[ADDR_HI:ADDR_LO];
  wire [15:0] wdata = fr.frame[15:0];
  wire wr_ctrl = fr.frame_done && !is_read && addr == ADDR_CTRL;
  wire sw_reset = wr_ctrl && wdata[BIT_SW_RESET];
  function automatic logic is_data(input logic [3:0] a);
    return a[3:2] == ADDR_DATA0[3:2];
  endfunction
  wire wr_data = fr.frame_done && !is_read && is_data(addr);
  // ==========================================================
  // state
  logic [15:0] ctrl_q;
  logic [11:0] in_q [NUM_CH];
  logic [11:0] lat_q [NUM_CH];
  logic [NUM_CH-1:0] dirty_q;
  logic ld_pin_q;
  logic [3:0] rd_addr_q;
  logic rd_pend_q;
  wire pin_event = ld_pin_q & ~ld_pin; // falling load pin
  wire bit_event = wr_ctrl && wdata[BIT_LOAD_ALL] && ld_pin;
  wire load_event = pin_event | bit_event;
  // control register; self-clearing bits never stored
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) ctrl_q <= CTRL_RESET;
    else if (sw_reset) ctrl_q <= CTRL_RESET;
    else if (wr_ctrl)
      ctrl_q <= wdata & CTRL_WMASK & ~16'h6000;
  end
  // input registers, latches and dirty marks
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    wire wr_this = wr_data && addr[1:0] == 2'(c);
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        in_q[c] <= 12'h000;
        lat_q[c] <= 12'h000;
        dirty_q[c] <= 1'b0;
      end else if (sw_reset) begin
        in_q[c] <= 12'h000;
        lat_q[c] <= 12'h000;
        dirty_q[c] <= 1'b0;
      end else begin
        if (wr_this) in_q[c] <= wdata[15:4];
        if (load_event && dirty_q[c]) lat_q[c] <= in_q[c];
        // a write in the load cycle stays marked
        if (wr_this) dirty_q[c] <= 1'b1;
        else if (load_event) dirty_q[c] <= 1'b0;
      end
    end
    assign channel_latch[c*12 +: 12] = lat_q[c];
  end
  // read address capture and pin history
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_addr_q <= 4'h0;
      rd_pend_q <= 1'b0;
      ld_pin_q <= 1'b1;
    end else begin
      ld_pin_q <= ld_pin;
      if (sw_reset) rd_pend_q <= 1'b0;
      else if (fr.frame_done) begin
        rd_pend_q <= is_read;
        rd_addr_q <= addr;
      end
    end
  end
  // ==========================================================
  // read mux
  wire [15:0] ctrl_rd = {ctrl_q[15:10], g1_sy[1], g0_sy[1],
    ctrl_q[7:0]};
  wire [11:0] ch_rd = ctrl_q[BIT_READ_SRC] ? lat_q[rd_addr_q[1:0]]
    : in_q[rd_addr_q[1:0]];
  assign fr.read_word = !rd_pend_q ? 16'h0000
    : rd_addr_q == ADDR_CTRL ? ctrl_rd
    : is_data(rd_addr_q) ? {ch_rd, 4'h0} : 16'h0000;
  // ==========================================================
  // pins
  assign sdo_out = sdo_bit;
  assign sdo_oe = !cs_sy[1] && !ctrl_q[BIT_SDO_DIS];
  assign gpio1_out = 1'b0;
  assign gpio1_oe = !ctrl_q[BIT_GPIO1];
  assign gpio0_out = 1'b0;
  assign gpio0_oe = !ctrl_q[BIT_GPIO0];
  assign channel_powerdown = {{2{ctrl_q[BIT_PD_B]}},
    {2{ctrl_q[BIT_PD_A]}}};
  assign channel_gain4 = ctrl_q[GAIN_HI:GAIN_LO];
  // ==========================================================
  // checks
  chk_reserved_zero: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    ctrl_q[10] == 1'b0 && ctrl_q[6] == 1'b0 && ctrl_q[1:0] == 2'h0)
    else $error("reserved bit set");
  chk_load_clears: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    wr_ctrl |=> !ctrl_q[BIT_LOAD_ALL] && !ctrl_q[BIT_SW_RESET])
    else $error("self-clearing bit stuck");
  chk_sw_reset_val: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    sw_reset |=> ctrl_q == CTRL_RESET && dirty_q == 4'h0)
    else $error("soft reset wrong");
  chk_load_pin_low: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    (wr_ctrl && !ld_pin && !pin_event && !sw_reset) |=> $stable(lat_q[0]))
    else $error("load bit acted with pin low");
  chk_clean_latch: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    !dirty_q[1] |=> $stable(lat_q[1]) || $past(sw_reset))
    else $error("clean latch reloaded");
  chk_bit_load: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    (bit_event && dirty_q[2] && !sw_reset) |=> lat_q[2] == $past(in_q[2]))
    else $error("load bit missed");
  chk_sdo_disabled: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    ctrl_q[BIT_SDO_DIS] |-> !sdo_oe)
    else $error("sdo driven while disabled");
  chk_write_frame: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    !fr.frame_done |=> ctrl_q == $past(ctrl_q))
    else $error("write without full frame");
  chk_pd_group: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    (wr_ctrl && !sw_reset) |=> channel_powerdown[0] == $past(wdata[12])
    && channel_powerdown[3] == $past(wdata[11]))
    else $error("powerdown mismatch");
  // register effects one cycle after a control write, then sdo drive and readback checks
  chk_pd_restore: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    (wr_ctrl && !sw_reset && !wdata[BIT_PD_A])
    |=> channel_powerdown[1:0] == 2'h0)
    else $error("group a stays powered down");
  chk_gain_bits: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    (wr_ctrl && !sw_reset) |=> channel_gain4 == $past(wdata[GAIN_HI:GAIN_LO]))
    else $error("gain bits mismatch");
  chk_gpio_drive: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    (wr_ctrl && !sw_reset) |=> gpio1_oe == !$past(wdata[BIT_GPIO1])
    && gpio0_oe == !$past(wdata[BIT_GPIO0]) && !gpio1_out && !gpio0_out)
    else $error("gpio drive mismatch");
  chk_sdo_enabled: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    (!ctrl_q[BIT_SDO_DIS] && !cs_sy[1]) |-> sdo_oe)
    else $error("sdo not driven while selected");
  chk_read_pend: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    (fr.frame_done && is_read) |=> rd_pend_q)
    else $error("read request lost");
  chk_read_source: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    (rd_pend_q && rd_addr_q == ADDR_DATA0 && ctrl_q[BIT_READ_SRC])
    |-> fr.read_word == {channel_latch[11:0], 4'h0})
    else $error("latch readback wrong");
endmodule
`default_nettype wire

// File: logic/qdc_frame_if.sv
/*
  Carrier between the serial shifter and the register bank.
  Assumes both ends run on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface qdc_frame_if;
  logic frame_done;
  logic [23:0] frame;
  logic frame_start;
  logic [15:0] read_word;
  modport shifter (output frame_done, output frame, output frame_start,
    input read_word);
  modport bank (input frame_done, input frame, input frame_start,
    output read_word);
endinterface
`default_nettype wire

// File: logic/qdc_pkg.sv
/*
  Shared constants for the quad converter control register block.
  Assumes a 100 MHz system clock and an SPI master with 24-bit frames.
*/
package qdc_pkg;
  // ==========================================================
  // frame layout
  localparam int FRAME_BITS = 24;
  localparam int FRAME_RW_BIT = 23;
  localparam int ADDR_HI = 19;
  localparam int ADDR_LO = 16;
  localparam int REG_BITS = 16;
  // ==========================================================
  // register addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_DATA0 = 4'h4;
  // ==========================================================
  // control register fields
  localparam int BIT_READ_SRC = 15;
  localparam int BIT_LOAD_ALL = 14;
  localparam int BIT_SW_RESET = 13;
  localparam int BIT_PD_A = 12;
  localparam int BIT_PD_B = 11;
  localparam int BIT_GPIO1 = 9;
  localparam int BIT_GPIO0 = 8;
  localparam int BIT_SDO_DIS = 7;
  localparam int GAIN_LO = 2;
  localparam int GAIN_HI = 5;
  localparam logic [15:0] CTRL_RESET = 16'h033c;
  localparam logic [15:0] CTRL_WMASK = 16'hfbbc; // no 10, 6, 1:0
  localparam logic [15:0] DATA_WMASK = 16'hfff0;
  localparam int NUM_CH = 4;
endpackage

// File: logic/qdc_spi_shift.sv
/*
  SPI mode-0 style shifter: samples on rising sclk, shifts out on falling.
  Assumes sclk, cs_b, sdi already pass two flip-flops in the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module qdc_spi_shift (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic sclk_s,
  input wire logic cs_b_s,
  input wire logic sdi_s,
  qdc_frame_if.shifter fr,
  output logic sdo_bit
);
  import qdc_pkg::*;
  // bit count at frame end and where reply data starts
  localparam logic [4:0] LAST_BIT = 5'(FRAME_BITS);
  localparam logic [4:0] FIRST_DATA = 5'(FRAME_BITS - REG_BITS);
  logic sclk_q, cs_q;
  logic [23:0] sh_q;
  logic [4:0] cnt_q;
  logic [15:0] out_q;
  logic sdo_q;
  wire rise = sclk_s & ~sclk_q;
  wire fall = ~sclk_s & sclk_q;
  wire cs_fall = ~cs_b_s & cs_q;
  wire cs_rise = cs_b_s & ~cs_q;
  wire data_phase = cnt_q >= FIRST_DATA && cnt_q < LAST_BIT;
  // edge history
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
    end else begin
      sclk_q <= sclk_s;
      cs_q <= cs_b_s;
    end
  end
  // shift in, count bits, emit read word msb first
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_q <= 24'h000000;
      cnt_q <= 5'h00;
      out_q <= 16'h0000;
      sdo_q <= 1'b0;
    end else if (cs_fall) begin
      cnt_q <= 5'h00;
      out_q <= fr.read_word;
      sdo_q <= 1'b0; // bit 23 of the reply frame is zero
    end else if (!cs_b_s && rise) begin
      sh_q <= {sh_q[22:0], sdi_s};
      if (cnt_q != LAST_BIT) cnt_q <= cnt_q + 5'h01;
    end else if (!cs_b_s && fall) begin
      // after bit 16 of the frame, data bits follow
      sdo_q <= data_phase ? out_q[15] : 1'b0;
      if (data_phase)
        out_q <= {out_q[14:0], 1'b0};
    end
  end
  assign fr.frame = sh_q;
  assign fr.frame_start = cs_fall;
  assign fr.frame_done = cs_rise && (cnt_q == LAST_BIT);
  assign sdo_bit = sdo_q;
endmodule
`default_nettype wire
